// ==== hw/adcf_pkg.sv ====
// Constants, types and operation summary for the ADC output formatter
// Summary of operation
// - Internal termination on doubles the driver current so swing is unchanged.
// - Over-range flag rides the same pipeline as the sample bits.
// - With clock invert at zero, receiver samples the flag in clock low.
// - Output clock can be delayed 0, 45, 90 or 135 degrees.
// - Clock inversion is independent of delay, giving 0 to 315 degrees in 45 degree steps.
// - Reset gives offset binary; two's complement inverts the top bit.
// - Midscale is 800h; out-of-range inputs clamp and raise the flag.
// - Scrambling XORs bit 0 into sample bits 11 down to 1.
// - Scrambling leaves bit 0, the flag and the output clock alone.
// - Alternate polarity inverts odd sample bits only.
// - Scrambling and alternate polarity enable independently.
// - Test enable forces flag and bits to ones, zeros, alternating or checker.
// - Test pattern overrides two's complement, scrambling and polarity.
// - Output disable floats all outputs, flag and clock included.
// - Sleep powers everything down; set by register or parallel pin.
// - Nap keeps the reference; at least 100 cycles to recover.
// - Even bit drives while clock is low, odd bit while high.
// - Flag is driven low in the second half of each period.
// - Phase code 00, 01, 10, 11 is 0, 1/8, 1/4, 3/8 period.
package adcf_pkg;
	localparam int SAMPLE_W = 12;
	localparam int PAIR_N = SAMPLE_W / 2;
	localparam int AIN_W = 14;
	localparam int PIPE_LATENCY = 6;
	localparam int MCLK_PERIOD_NS = 100;
	localparam int ENC_PERIOD_NS = 800;
	localparam int ENC_CYC = ENC_PERIOD_NS / MCLK_PERIOD_NS;
	localparam int ENC_HALF = ENC_CYC / 2;
	localparam int PHASE_STEP_RAW = ENC_CYC / 8;
	localparam int PHASE_STEP_CYC = (PHASE_STEP_RAW < 1) ? 1 : PHASE_STEP_RAW;
	localparam int PH_CNT_W = 4;
	localparam int NAP_RECOVER_SAMPLES = 100;
	localparam logic [1:0] PHASE_NONE = 2'h0;
	localparam logic [1:0] PHASE_QUARTER = 2'h2;
	localparam logic [11:0] CODE_MAX = 12'hFFF;
	localparam logic [11:0] CODE_MIN = 12'h000;
	localparam logic [11:0] CODE_MSB = 12'h800;
	localparam logic [11:0] ODD_MASK = 12'hAAA;
	localparam logic signed [13:0] AIN_MAX = 14'sh07FF;
	localparam logic signed [13:0] AIN_MIN = 14'sh3800;
	localparam int APB_AW = 8;
	localparam logic [7:0] ADDR_POWER = 8'h00;
	localparam logic [7:0] ADDR_TIMING = 8'h04;
	localparam logic [7:0] ADDR_OUTMODE = 8'h08;
	localparam logic [7:0] ADDR_FORMAT = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [31:0] REG_RST = 32'h0000_0000;
	localparam int PWR_SLEEP_BIT = 0;
	localparam int PWR_NAP_BIT = 1;
	localparam int TIM_DCS_BIT = 0;
	localparam int TIM_PHASE_LSB = 1;
	localparam int TIM_INV_BIT = 3;
	localparam int OUT_OFF_BIT = 0;
	localparam int OUT_TERM_BIT = 1;
	localparam int OUT_CUR_LSB = 2;
	localparam int FMT_TWOS_BIT = 0;
	localparam int FMT_SCRAMBLE_BIT = 1;
	localparam int FMT_ABP_BIT = 2;
	localparam int FMT_TEST_BIT = 3;
	localparam int FMT_TSEL_LSB = 4;
	localparam int ST_READY_BIT = 0;
	localparam int ST_PWR_LSB = 1;
	localparam int ST_PAR_BIT = 5;

	typedef enum logic [1:0] {
		TP_ONES = 2'h0,
		TP_ZEROS = 2'h1,
		TP_ALT = 2'h2,
		TP_CHECK = 2'h3
	} adcf_tp_t;

	typedef enum logic [3:0] {
		PWR_RUN = 4'h1,
		PWR_NAP = 4'h2,
		PWR_SLEEP = 4'h4,
		PWR_WAKE = 4'h8
	} adcf_pwr_t;

	typedef struct packed {
		logic over_range;
		logic [SAMPLE_W-1:0] bits;
	} adcf_word_t;

	typedef struct packed {
		logic twos;
		logic scramble;
		logic abp;
		logic test_en;
		adcf_tp_t test_sel;
	} adcf_fmt_cfg_t;

	localparam adcf_word_t PAT_ONES = 13'h1FFF;
	localparam adcf_word_t PAT_ZEROS = 13'h0000;
	localparam adcf_word_t CHECK_A = 13'h1555;
	localparam adcf_word_t CHECK_B = 13'h0AAA;
endpackage

// ==== hw/adcf_formatter.sv ====
// Sample formatter: code select, scramble, alternate polarity, test patterns
`timescale 1ns/1ps
`default_nettype none
module adcf_formatter (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	// Sample in
	input wire logic i_load,
	input wire adcf_pkg::adcf_word_t i_word,
	input wire adcf_pkg::adcf_fmt_cfg_t i_cfg,
	// Formatted sample out
	output adcf_pkg::adcf_word_t o_word
);
	import adcf_pkg::*;

	adcf_word_t word_ff, nxt_word, coded;
	logic alt_ff, nxt_alt;

	always_comb begin
		coded = i_word;
		if (i_cfg.twos) begin
			coded.bits = coded.bits ^ CODE_MSB;
		end
		if (i_cfg.scramble) begin
			coded.bits[SAMPLE_W-1:1] = coded.bits[SAMPLE_W-1:1]
				^ {(SAMPLE_W-1){coded.bits[0]}};
		end
		if (i_cfg.abp) begin
			coded.bits = coded.bits ^ ODD_MASK;
		end
		nxt_word = word_ff;
		nxt_alt = alt_ff;
		if (i_load) begin
			nxt_alt = ~alt_ff;
			nxt_word = coded;
			if (i_cfg.test_en) begin
				case (i_cfg.test_sel)
					TP_ONES: nxt_word = PAT_ONES;
					TP_ZEROS: nxt_word = PAT_ZEROS;
					TP_ALT: nxt_word = alt_ff ? PAT_ZEROS : PAT_ONES;
					default: nxt_word = alt_ff ? CHECK_B : CHECK_A;
				endcase
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			word_ff <= PAT_ZEROS;
			alt_ff <= 1'b0;
		end else begin
			word_ff <= nxt_word;
			alt_ff <= nxt_alt;
		end
	end

	assign o_word = word_ff;

	default clocking fcb @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);

	a_test_ones: assert property (
		(i_load && i_cfg.test_en && i_cfg.test_sel == TP_ONES)
		|=> o_word == PAT_ONES)
		else $error("All-ones pattern not driven");
	a_test_checker: assert property (
		(i_load && i_cfg.test_en && i_cfg.test_sel == TP_CHECK)
		|=> o_word == ($past(alt_ff) ? CHECK_B : CHECK_A))
		else $error("Checker pattern wrong or altered");
	a_lsb_kept: assert property (
		(i_load && !i_cfg.test_en) |=> (o_word.bits[0] == $past(i_word.bits[0])
		&& o_word.over_range == $past(i_word.over_range)))
		else $error("Bit 0 or flag changed by formatting");
	a_alt_polarity: assert property (
		(i_load && !i_cfg.test_en && !i_cfg.twos && !i_cfg.scramble
		&& i_cfg.abp) |=> o_word.bits == ($past(i_word.bits) ^ ODD_MASK))
		else $error("Alternate polarity wrong");
	a_twos_msb: assert property (
		(i_load && !i_cfg.test_en && i_cfg.twos && !i_cfg.scramble
		&& !i_cfg.abp) |=> o_word.bits == ($past(i_word.bits) ^ CODE_MSB))
		else $error("Two's complement coding wrong");
	a_scramble_xor: assert property (
		(i_load && !i_cfg.test_en && !i_cfg.twos && !i_cfg.abp
		&& i_cfg.scramble) |=> o_word.bits[SAMPLE_W-1:1]
		== ($past(i_word.bits[SAMPLE_W-1:1])
		^ {(SAMPLE_W-1){$past(i_word.bits[0])}}))
		else $error("Scrambled bits wrong");

	c_both_modes: cover property (i_load && i_cfg.scramble && i_cfg.abp);
endmodule
`default_nettype wire

// ==== hw/adcf_top.sv ====
// Top level: APB registers, sampling, pipeline, DDR output stage, power
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module adcf_top #(
	parameter int LATENCY = adcf_pkg::PIPE_LATENCY,
	parameter int NAP_RECOVER = adcf_pkg::NAP_RECOVER_SAMPLES
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [adcf_pkg::APB_AW-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Sampling clock, quantiser result and parallel pins
	input wire logic i_enc,
	input wire logic [adcf_pkg::AIN_W-1:0] i_ain_code,
	input wire logic i_par_mode,
	input wire logic i_par_sleep,
	input wire logic i_par_dcs,
	// LVDS output stage
	output logic [adcf_pkg::PAIR_N-1:0] o_sample_bits_ddr,
	output logic o_over_range_flag,
	output logic o_data_output_clock,
	output logic o_lvds_oe,
	output logic o_term_on,
	output logic o_drive_double,
	output logic [2:0] o_drive_current,
	// Power and clock conditioning
	output logic o_dcs_on,
	output logic o_core_pd,
	output logic o_ref_pd,
	output logic o_sample_ready
);
	import adcf_pkg::*;

	localparam int DLY_LEN = 3 * PHASE_STEP_CYC;
	localparam int WK_W = $clog2(NAP_RECOVER + 1);
	localparam int SYNC_W = AIN_W + 4;

	// Two flops on the enc, parallel and code pins; enc edge found on the synced copy only
	logic [SYNC_W-1:0] sync1_ff, sync2_ff;
	logic enc_prev_ff;
	logic enc_rise, par_mode_s, par_sleep_s, par_dcs_s;
	logic signed [AIN_W-1:0] ain_s;

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
			enc_prev_ff <= 1'b0;
		end else begin
			sync1_ff <= {i_enc, i_par_mode, i_par_sleep, i_par_dcs, i_ain_code};
			sync2_ff <= sync1_ff;
			enc_prev_ff <= sync2_ff[SYNC_W-1];
		end
	end

	assign enc_rise = sync2_ff[SYNC_W-1] & ~enc_prev_ff;
	assign par_mode_s = sync2_ff[SYNC_W-2];
	assign par_sleep_s = sync2_ff[SYNC_W-3];
	assign par_dcs_s = sync2_ff[SYNC_W-4];
	assign ain_s = $signed(sync2_ff[AIN_W-1:0]);

	// Register file
	logic wr_en, rd_setup, addr_hit;
	logic pwr_sleep_ff, nxt_pwr_sleep, pwr_nap_ff, nxt_pwr_nap;
	logic tim_dcs_ff, nxt_tim_dcs, tim_inv_ff, nxt_tim_inv;
	logic [1:0] tim_phase_ff, nxt_tim_phase;
	logic out_off_ff, nxt_out_off, out_term_ff, nxt_out_term;
	logic [2:0] out_cur_ff, nxt_out_cur;
	adcf_fmt_cfg_t fmt_ff, nxt_fmt;
	logic [31:0] prdata_ff, nxt_prdata, rd_word;
	adcf_pwr_t pwr_state_ff, nxt_pwr_state;

	assign wr_en = i_psel & i_penable & i_pwrite;
	assign rd_setup = i_psel & ~i_penable & ~i_pwrite;

	always_comb begin
		addr_hit = 1'b1;
		rd_word = REG_RST;
		if (i_paddr == ADDR_POWER) begin
			rd_word[PWR_SLEEP_BIT] = pwr_sleep_ff;
			rd_word[PWR_NAP_BIT] = pwr_nap_ff;
		end else if (i_paddr == ADDR_TIMING) begin
			rd_word[TIM_DCS_BIT] = tim_dcs_ff;
			rd_word[TIM_PHASE_LSB +: 2] = tim_phase_ff;
			rd_word[TIM_INV_BIT] = tim_inv_ff;
		end else if (i_paddr == ADDR_OUTMODE) begin
			rd_word[OUT_OFF_BIT] = out_off_ff;
			rd_word[OUT_TERM_BIT] = out_term_ff;
			rd_word[OUT_CUR_LSB +: 3] = out_cur_ff;
		end else if (i_paddr == ADDR_FORMAT) begin
			rd_word[FMT_TWOS_BIT] = fmt_ff.twos;
			rd_word[FMT_SCRAMBLE_BIT] = fmt_ff.scramble;
			rd_word[FMT_ABP_BIT] = fmt_ff.abp;
			rd_word[FMT_TEST_BIT] = fmt_ff.test_en;
			rd_word[FMT_TSEL_LSB +: 2] = fmt_ff.test_sel;
		end else if (i_paddr == ADDR_STATUS) begin
			rd_word[ST_READY_BIT] = o_sample_ready;
			rd_word[ST_PWR_LSB +: 4] = pwr_state_ff;
			rd_word[ST_PAR_BIT] = par_mode_s;
		end else begin
			addr_hit = 1'b0;
		end
	end

	always_comb begin
		nxt_pwr_sleep = pwr_sleep_ff;
		nxt_pwr_nap = pwr_nap_ff;
		nxt_tim_dcs = tim_dcs_ff;
		nxt_tim_phase = tim_phase_ff;
		nxt_tim_inv = tim_inv_ff;
		nxt_out_off = out_off_ff;
		nxt_out_term = out_term_ff;
		nxt_out_cur = out_cur_ff;
		nxt_fmt = fmt_ff;
		nxt_prdata = prdata_ff;
		// Read data is latched in setup so access needs no wait state
		if (rd_setup) begin
			nxt_prdata = rd_word;
		end
		if (wr_en) begin
			if (i_paddr == ADDR_POWER) begin
				nxt_pwr_sleep = i_pwdata[PWR_SLEEP_BIT];
				nxt_pwr_nap = i_pwdata[PWR_NAP_BIT];
			end else if (i_paddr == ADDR_TIMING) begin
				nxt_tim_dcs = i_pwdata[TIM_DCS_BIT];
				nxt_tim_phase = i_pwdata[TIM_PHASE_LSB +: 2];
				nxt_tim_inv = i_pwdata[TIM_INV_BIT];
			end else if (i_paddr == ADDR_OUTMODE) begin
				nxt_out_off = i_pwdata[OUT_OFF_BIT];
				nxt_out_term = i_pwdata[OUT_TERM_BIT];
				nxt_out_cur = i_pwdata[OUT_CUR_LSB +: 3];
			end else if (i_paddr == ADDR_FORMAT) begin
				nxt_fmt.twos = i_pwdata[FMT_TWOS_BIT];
				nxt_fmt.scramble = i_pwdata[FMT_SCRAMBLE_BIT];
				nxt_fmt.abp = i_pwdata[FMT_ABP_BIT];
				nxt_fmt.test_en = i_pwdata[FMT_TEST_BIT];
				nxt_fmt.test_sel = adcf_tp_t'(i_pwdata[FMT_TSEL_LSB +: 2]);
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			pwr_sleep_ff <= 1'b0;
			pwr_nap_ff <= 1'b0;
			tim_dcs_ff <= 1'b0;
			tim_phase_ff <= PHASE_NONE;
			tim_inv_ff <= 1'b0;
			out_off_ff <= 1'b0;
			out_term_ff <= 1'b0;
			out_cur_ff <= '0;
			fmt_ff <= '0;
			prdata_ff <= REG_RST;
		end else begin
			pwr_sleep_ff <= nxt_pwr_sleep;
			pwr_nap_ff <= nxt_pwr_nap;
			tim_dcs_ff <= nxt_tim_dcs;
			tim_phase_ff <= nxt_tim_phase;
			tim_inv_ff <= nxt_tim_inv;
			out_off_ff <= nxt_out_off;
			out_term_ff <= nxt_out_term;
			out_cur_ff <= nxt_out_cur;
			fmt_ff <= nxt_fmt;
			prdata_ff <= nxt_prdata;
		end
	end

	assign o_prdata = prdata_ff;
	assign o_pready = 1'b1;
	assign o_pslverr = i_psel & i_penable & ~addr_hit;

	// Power states; wake counts sampling edges, so it stalls without a clock
	logic sleep_req, nap_req;
	logic [WK_W-1:0] wake_cnt_ff, nxt_wake_cnt;

	assign sleep_req = par_mode_s ? par_sleep_s : pwr_sleep_ff;
	assign nap_req = ~par_mode_s & pwr_nap_ff;

	always_comb begin
		nxt_pwr_state = pwr_state_ff;
		nxt_wake_cnt = wake_cnt_ff;
		if (sleep_req) begin
			nxt_pwr_state = PWR_SLEEP;
			nxt_wake_cnt = '0;
		end else if (nap_req) begin
			nxt_pwr_state = PWR_NAP;
			nxt_wake_cnt = '0;
		end else begin
			case (pwr_state_ff)
				PWR_SLEEP, PWR_NAP: nxt_pwr_state = PWR_WAKE;
				PWR_WAKE: begin
					if (enc_rise) begin
						if (wake_cnt_ff == WK_W'(NAP_RECOVER - 1)) begin
							nxt_pwr_state = PWR_RUN;
						end else begin
							nxt_wake_cnt = wake_cnt_ff + 1'b1;
						end
					end
				end
				default: nxt_pwr_state = PWR_RUN;
			endcase
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			pwr_state_ff <= PWR_WAKE;
			wake_cnt_ff <= '0;
		end else begin
			pwr_state_ff <= nxt_pwr_state;
			wake_cnt_ff <= nxt_wake_cnt;
		end
	end

	assign o_core_pd = (pwr_state_ff == PWR_NAP) | (pwr_state_ff == PWR_SLEEP);
	assign o_ref_pd = pwr_state_ff == PWR_SLEEP;
	assign o_sample_ready = pwr_state_ff == PWR_RUN;

	// Sample capture and latency pipeline
	adcf_word_t clamp_word, fmt_word;
	adcf_word_t pipe_ff [0:LATENCY-1];
	adcf_word_t nxt_pipe [0:LATENCY-1];

	always_comb begin
		clamp_word.over_range = 1'b0;
		clamp_word.bits = ain_s[SAMPLE_W-1:0] ^ CODE_MSB;
		if (ain_s > AIN_MAX) begin
			clamp_word.over_range = 1'b1;
			clamp_word.bits = CODE_MAX;
		end else if (ain_s < AIN_MIN) begin
			clamp_word.over_range = 1'b1;
			clamp_word.bits = CODE_MIN;
		end
	end

	always_comb begin
		for (int i = 0; i < LATENCY; i++) begin
			nxt_pipe[i] = pipe_ff[i];
		end
		if (enc_rise && !o_core_pd) begin
			nxt_pipe[0] = clamp_word;
			for (int i = 1; i < LATENCY; i++) begin
				nxt_pipe[i] = pipe_ff[i-1];
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		for (int i = 0; i < LATENCY; i++) begin
			if (i_sys_rst) begin
				pipe_ff[i] <= PAT_ZEROS;
			end else begin
				pipe_ff[i] <= nxt_pipe[i];
			end
		end
	end

	adcf_formatter u_formatter (
		.i_mclk(i_mclk),
		.i_sys_rst(i_sys_rst),
		.i_load(enc_rise),
		.i_word(pipe_ff[LATENCY-1]),
		.i_cfg(fmt_ff),
		.o_word(fmt_word)
	);

	// DDR serializer and output clock
	logic [PH_CNT_W-1:0] ph_cnt_ff, nxt_ph_cnt;
	logic [DLY_LEN-1:0] clk_dly_ff, nxt_clk_dly;
	logic [PAIR_N-1:0] even_bits, odd_bits, ddr_ff, nxt_ddr;
	logic base_clk, clk_tap, ovr_ff, nxt_ovr, oclk_ff, nxt_oclk;

	assign base_clk = ph_cnt_ff >= PH_CNT_W'(ENC_HALF);

	generate
		for (genvar g = 0; g < PAIR_N; g++) begin : g_pair
			assign even_bits[g] = fmt_word.bits[2*g];
			assign odd_bits[g] = fmt_word.bits[2*g+1];
		end
	endgenerate

	always_comb begin
		nxt_ph_cnt = ph_cnt_ff;
		if (enc_rise) begin
			nxt_ph_cnt = '0;
		end else if (ph_cnt_ff != PH_CNT_W'(ENC_CYC - 1)) begin
			nxt_ph_cnt = ph_cnt_ff + 1'b1;
		end
		nxt_clk_dly = {clk_dly_ff[DLY_LEN-2:0], base_clk};
		clk_tap = base_clk;
		if (tim_phase_ff != PHASE_NONE) begin
			clk_tap = clk_dly_ff[tim_phase_ff * PHASE_STEP_CYC - 1];
		end
		nxt_oclk = clk_tap ^ tim_inv_ff;
		nxt_ddr = base_clk ? odd_bits : even_bits;
		nxt_ovr = base_clk ? 1'b0 : fmt_word.over_range;
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			ph_cnt_ff <= '0;
			clk_dly_ff <= '0;
			ddr_ff <= '0;
			ovr_ff <= 1'b0;
			oclk_ff <= 1'b0;
		end else begin
			ph_cnt_ff <= nxt_ph_cnt;
			clk_dly_ff <= nxt_clk_dly;
			ddr_ff <= nxt_ddr;
			ovr_ff <= nxt_ovr;
			oclk_ff <= nxt_oclk;
		end
	end

	assign o_sample_bits_ddr = ddr_ff;
	assign o_over_range_flag = ovr_ff;
	assign o_data_output_clock = oclk_ff;
	assign o_lvds_oe = ~out_off_ff;
	assign o_term_on = out_term_ff;
	assign o_drive_double = out_term_ff;
	assign o_drive_current = out_cur_ff;
	// Stabilizer must be on for nonzero phase; software enforces that
	assign o_dcs_on = par_mode_s ? par_dcs_s : tim_dcs_ff;

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);

	a_ovr_second_half: assert property (
		base_clk |=> !o_over_range_flag)
		else $error("Over-range flag high in second half");
	a_ddr_even_low: assert property (
		!base_clk |=> o_sample_bits_ddr == $past(even_bits))
		else $error("Even bits not driven in low half");
	a_out_disable: assert property (
		(wr_en && i_paddr == ADDR_OUTMODE && i_pwdata[OUT_OFF_BIT])
		|=> !o_lvds_oe)
		else $error("Outputs still driven after disable");
	a_term_double: assert property (
		(wr_en && i_paddr == ADDR_OUTMODE && i_pwdata[OUT_TERM_BIT])
		|=> (o_term_on && o_drive_double))
		else $error("Drive not doubled with termination");
	a_sleep_power: assert property (
		sleep_req |=> (o_core_pd && o_ref_pd && !o_sample_ready))
		else $error("Sleep did not power down all");
	a_nap_power: assert property (
		(nap_req && !sleep_req) |=> (o_core_pd && !o_ref_pd))
		else $error("Nap power state wrong");
	a_nap_recover: assert property (
		$rose(o_sample_ready) |-> ($past(wake_cnt_ff) == WK_W'(NAP_RECOVER - 1)
		&& $past(enc_rise)))
		else $error("Samples ready before recovery count");
	a_clk_quarter: assert property (
		(tim_phase_ff == PHASE_QUARTER && !tim_inv_ff)
		|=> o_data_output_clock == $past(base_clk, 3))
		else $error("Quarter period clock delay wrong");
	a_clk_invert: assert property (
		(tim_phase_ff == PHASE_NONE && tim_inv_ff)
		|=> o_data_output_clock != $past(base_clk))
		else $error("Output clock not inverted");
	a_clamp_high: assert property (
		(enc_rise && !o_core_pd && ain_s > AIN_MAX)
		|=> (pipe_ff[0].over_range && pipe_ff[0].bits == CODE_MAX))
		else $error("Over-range input not clamped");

	c_test_pattern: cover property (enc_rise && fmt_ff.test_en);
	c_wake_done: cover property ($rose(o_sample_ready));
	c_over_range: cover property ($rose(o_over_range_flag));
endmodule
`default_nettype wire

// ==== verif/adcf_rx_model.sv ====
// Receiving logic model: captures DDR samples on output clock edges
`timescale 1ns/1ps
`default_nettype none
module adcf_rx_model (
	// Clock
	input wire logic i_mclk,
	// LVDS lines from the converter
	input wire logic [adcf_pkg::PAIR_N-1:0] i_ddr,
	input wire logic i_flag,
	input wire logic i_clk_out,
	// Captured sample
	output adcf_pkg::adcf_word_t o_word,
	output logic o_hi_flag,
	output logic o_valid
);
	import adcf_pkg::*;
	logic clk_d = 1'b0;
	logic flag_d = 1'b0;
	logic of_ff = 1'b0;
	logic [PAIR_N-1:0] ddr_d = '0;
	logic [PAIR_N-1:0] even_ff = '0;
	initial o_valid = 1'b0;
	// Data moves with the clock edges, so the value held one mclk
	// earlier is the settled half that the edge closes
	always @(posedge i_mclk) begin
		clk_d <= i_clk_out;
		ddr_d <= i_ddr;
		flag_d <= i_flag;
		o_valid <= 1'b0;
		// even bits and flag while clock low
		if (i_clk_out && !clk_d) begin
			even_ff <= ddr_d;
			of_ff <= flag_d;
		end
		if (!i_clk_out && clk_d) begin
			for (int i = 0; i < PAIR_N; i++) begin
				o_word.bits[2*i] <= even_ff[i];
				o_word.bits[2*i+1] <= ddr_d[i];
			end
			o_word.over_range <= of_ff;
			o_hi_flag <= flag_d;
			o_valid <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
// Self-checking bench for the output formatter top level
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import adcf_pkg::*;
	localparam int NAPR = 3;
	// Sleep settle: 0.1 ms of mclk plus 2500 sampling periods
	localparam int SLEEP_SETTLE = 100_000 / MCLK_PERIOD_NS + 2500 * ENC_CYC;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic enc = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [13:0] ain = 14'h0000;
	logic par_mode = 1'b0;
	logic par_sleep = 1'b0;
	logic par_dcs = 1'b0;
	logic [31:0] prdata;
	logic pready, pslverr, oclk, flag, oe, term, dbl;
	logic core_pd, ref_pd, ready, rx_hi, rx_valid;
	logic dcs;
	logic [2:0] cur;
	logic [PAIR_N-1:0] ddr;
	adcf_word_t rx_word;
	int cyc = 0;
	int mismatches = 0;
	int num_checks = 0;
	logic [13:0] t_ain [9] = '{14'h0000, 14'h07FF, 14'h0BB8, 14'h3448,
		14'h0005, 14'h0005, 14'h0005, 14'h0005, 14'h0005};
	logic [5:0] t_fmt [9] = '{6'h00, 6'h01, 6'h00, 6'h00, 6'h02, 6'h04,
		6'h06, 6'h0F, 6'h1F};
	logic [12:0] t_exp [9] = '{13'h0800, 13'h07FF, 13'h1FFF, 13'h1000,
		13'h07FB, 13'h02AF, 13'h0D51, 13'h1FFF, 13'h0000};
	always #50 mclk = ~mclk;
	// Sampling clock of 8 mclk periods, launched off the mclk edge
	// clock runs through nap
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc % 4 == 3)
			enc <= ~enc;
	end
	adcf_top #(.NAP_RECOVER(NAPR)) i_dut (.i_mclk(mclk), .i_sys_rst(rst),
		.i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .i_enc(enc), .i_ain_code(ain),
		.i_par_mode(par_mode), .i_par_sleep(par_sleep),
		.i_par_dcs(par_dcs),
		.o_sample_bits_ddr(ddr), .o_over_range_flag(flag),
		.o_data_output_clock(oclk), .o_lvds_oe(oe), .o_term_on(term),
		.o_drive_double(dbl), .o_drive_current(cur), .o_dcs_on(dcs),
		.o_core_pd(core_pd), .o_ref_pd(ref_pd), .o_sample_ready(ready));
	adcf_rx_model i_rx (.i_mclk(mclk), .i_ddr(ddr), .i_flag(flag),
		.i_clk_out(oclk), .o_word(rx_word), .o_hi_flag(rx_hi),
		.o_valid(rx_valid));
	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic hang;
		mismatches++;
		close_out();
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		int n;
		n = 0;
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		pen <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1)
			hang();
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		// Idle edge, so a following call never reassigns psel in this step
		@(posedge mclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic get_word(output adcf_word_t w);
		int n;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (rx_valid !== 1'b1 && n < 40);
		if (rx_valid !== 1'b1)
			hang();
		w = rx_word;
	endtask
	task automatic rise_pos(output int p);
		logic prev;
		logic cur;
		int n;
		cur = 1'b1;
		n = 0;
		do begin
			prev = cur;
			@(posedge mclk);
			cur = oclk;
			n++;
		end while (!(cur === 1'b1 && prev === 1'b0) && n < 40);
		if (!(cur === 1'b1 && prev === 1'b0))
			hang();
		p = cyc % 8;
	endtask
	initial begin
		adcf_word_t w;
		adcf_word_t w2;
		logic [SAMPLE_W-1:0] d;
		logic [31:0] q;
		logic e;
		int t0;
		int p;
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		repeat (3) @(posedge mclk);
		apb(1'b0, ADDR_FORMAT, 32'h0000_0000, q, e);
		chk("format reset", 16'h0000, q[15:0]);
		apb(1'b0, 8'h14, 32'h0000_0000, q, e);
		chk("unmapped", 16'h0001, {q[14:0], e});
		for (int r = 0; r < 9; r++) begin
			ain <= t_ain[r];
			wr(ADDR_FORMAT, {26'h000_0000, t_fmt[r]});
			repeat (12) get_word(w);
			chk("sample", {3'h0, t_exp[r]}, {3'h0, w});
			if (t_fmt[r][3] == 1'b0)
				chk("flag high half", 16'h0000, {15'h0000, rx_hi});
			d = w.bits;
			if (t_fmt[r][2])
				d = d ^ ODD_MASK;
			if (t_fmt[r][1])
				d[SAMPLE_W-1:1] = d[SAMPLE_W-1:1] ^ {(SAMPLE_W-1){d[0]}};
			if (t_fmt[r][3] == 1'b0 && t_fmt[r][2:1] != 2'h0)
				chk("decoded", 16'h0805, {4'h0, d});
		end
		for (int s = 2; s < 4; s++) begin
			wr(ADDR_FORMAT, {26'h000_0000, 2'(s), 4'h8});
			repeat (12) get_word(w);
			get_word(w2);
			chk("pattern swap", 16'h1FFF, {3'h0, w ^ w2});
			e = (s == 2) ? (w === PAT_ONES || w === PAT_ZEROS) :
				(w === CHECK_A || w === CHECK_B);
			chk("pattern value", 16'h0001, {15'h0000, e});
		end
		// Stabilizer goes on before any nonzero clock delay
		wr(ADDR_TIMING, 32'h0000_0001);
		chk("stabilizer", 16'h0001, {15'h0000, dcs});
		repeat (20) @(posedge mclk);
		rise_pos(t0);
		for (int j = 1; j < 8; j++) begin
			wr(ADDR_TIMING, {28'h000_0000, 3'(j), 1'b1});
			repeat (20) @(posedge mclk);
			rise_pos(p);
			chk("clock rise", 16'((t0 + j % 4 + 4 * (j / 4)) % 8), 16'(p));
		end
		wr(ADDR_OUTMODE, 32'h0000_0001);
		repeat (2) @(posedge mclk);
		chk("disable", 16'h0000, {15'h0000, oe});
		wr(ADDR_OUTMODE, 32'h0000_0016);
		repeat (2) @(posedge mclk);
		chk("termination", 16'h003D, {10'h000, oe, term, dbl, cur});
		wr(ADDR_POWER, 32'h0000_0002);
		repeat (2) @(posedge mclk);
		chk("nap", 16'h0002, {14'h0000, core_pd, ref_pd});
		wr(ADDR_POWER, 32'h0000_0000);
		repeat (2) @(posedge mclk);
		chk("nap recovering", 16'h0000, {15'h0000, ready});
		repeat (8 * NAPR + 16) @(posedge mclk);
		chk("nap recovered", 16'h0001, {15'h0000, ready});
		wr(ADDR_POWER, 32'h0000_0001);
		repeat (2) @(posedge mclk);
		chk("sleep", 16'h0003, {14'h0000, core_pd, ref_pd});
		// Parallel mode: the pins, not the register, decide sleep
		par_mode <= 1'b1;
		repeat (4) @(posedge mclk);
		chk("pin wake", 16'h0000, {13'h0000, core_pd, ref_pd, dcs});
		par_sleep <= 1'b1;
		par_dcs <= 1'b1;
		repeat (4) @(posedge mclk);
		chk("pin sleep", 16'h0007, {13'h0000, core_pd, ref_pd, dcs});
		apb(1'b0, ADDR_STATUS, 32'h0000_0000, q, e);
		chk("status", 16'h0028, q[15:0]);
		// Mid-run reset straight out of pin sleep
		rst <= 1'b1;
		par_mode <= 1'b0;
		par_sleep <= 1'b0;
		par_dcs <= 1'b0;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		repeat (3) @(posedge mclk);
		chk("reset outputs", 16'h0200, {6'h00, oe, term, dbl, cur,
			core_pd, ref_pd, ready, dcs});
		apb(1'b0, ADDR_FORMAT, 32'h0000_0000, q, e);
		chk("format after reset", 16'h0000, q[15:0]);
		repeat (SLEEP_SETTLE) @(posedge mclk);
		get_word(w);
		chk("sample after reset", 16'h0805, {3'h0, w});
		close_out();
	end
endmodule
`default_nettype wire
